// ---- pamx_port_mux.v ----
// Alternate-function pin mux for ports A, B and C with AXI4-Lite registers
//
// Contract
// - Port A has no function-set registers; only the per-pin enable exists.
// - Enabling a port A pin connects its single peripheral signal directly.
// - PA0 and PA6 carry timer input or complement; timer mode decides.
// - PA4 is shared UART/infrared receive, PA5 shared transmit.
// - PA2 is UART driver enable, PA3 is UART clear to send.
// - PA1 is timer zero output, PA7 is timer one output.
// - Port B second set register exists but never steers selection.
// - Port B first set bit chooses: analog, reference, clock or reserved.
// - Port C second set register exists but is ignored.
// - PC0 and PC1 with bit set give analog, comparator or LED drive.
// - PC2 analog/LED/reference; PC3 comparator or LED; PC4-7 LED.
// - Reference on PB5 only in the 28-pin package.
// - Reference on PC2 only in the 20-pin package.
// - Analog functions need both the pin enable and the select bit.
// - An enabled alternate function drives the pad output enable.
`timescale 1ns/1ns
`include "pamx_defines.vh"
module pamx_port_mux #(
  parameter [5:0] PKG_PINS = `PAMX_PKG_28  // Package pin count, 20 or 28
) (
  input wire clock_in,                  // System clock, 250 MHz
  input wire resetn_in,                 // Synchronous reset, active low
  input wire [7:0] s_axi_awaddr,        // Write address
  input wire s_axi_awvalid,             // Write address valid
  output wire s_axi_awready,            // Write address ready
  input wire [31:0] s_axi_wdata,        // Write data
  input wire [3:0] s_axi_wstrb,         // Write byte strobes
  input wire s_axi_wvalid,              // Write data valid
  output wire s_axi_wready,             // Write data ready
  output reg [1:0] s_axi_bresp,         // Write response
  output reg s_axi_bvalid,              // Write response valid
  input wire s_axi_bready,              // Write response ready
  input wire [7:0] s_axi_araddr,        // Read address
  input wire s_axi_arvalid,             // Read address valid
  output wire s_axi_arready,            // Read address ready
  output reg [31:0] s_axi_rdata,        // Read data
  output reg [1:0] s_axi_rresp,         // Read response
  output reg s_axi_rvalid,              // Read data valid
  input wire s_axi_rready,              // Read data ready
  input wire [23:0] pad_in,             // Pad levels, port*8+pin
  output wire [23:0] pad_out,           // Pad output levels
  output wire [23:0] pad_oe_out,        // Pad output enables
  output wire [23:0] analog_connect_out,// Pad tied to analog bus
  input wire timer_zero_output_in,      // Timer 0 output
  input wire timer_zero_compl_in,       // Timer 0 output complement
  input wire timer_zero_pin_drive_in,   // Timer 0 mode drives PA0
  output wire timer_zero_input_out,     // Timer 0 input from PA0
  input wire timer_one_output_in,       // Timer 1 output
  input wire timer_one_compl_in,        // Timer 1 output complement
  input wire timer_one_pin_drive_in,    // Timer 1 mode drives PA6
  output wire timer_one_input_out,      // Timer 1 input from PA6
  input wire uart_zero_driver_enable_in,// UART 0 driver enable
  output wire uart_zero_clear_to_send_out, // UART 0 clear to send
  output wire uart_zero_receive_out,    // UART/infrared receive
  input wire uart_zero_transmit_in,     // UART/infrared transmit
  output wire external_clock_input_out, // External clock from PB3
  input wire comparator_output_in,      // Comparator output for PC3
  input wire [7:0] led_enable_in,       // LED drive enables, port C
  input wire adc_ref_select_in,         // ADC wants external reference
  output reg [1:0] adc_ref_pad_out      // Reference on [0] PB5, [1] PC2
);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  reg [7:0] port_out [0:2];
  reg [7:0] port_dir [0:2];
  reg [7:0] alt_en [0:2];
  reg [7:0] function_select_first [1:2];
  reg [7:0] function_select_second [1:2];
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [7:0] w_data;
  reg w_lane0;
  wire [1:0] wr_bank;
  wire [2:0] wr_reg;
  wire wr_fire;
  wire wr_hit;
  wire [1:0] rd_bank;
  wire [2:0] rd_reg;
  wire rd_bank_ok;
  wire [23:0] alt_in;
  wire pkg28;
  wire pkg20;
  reg [23:0] alt_use;
  reg [23:0] alt_out;
  reg [23:0] alt_oe;
  reg [23:0] alt_ana;
  reg [7:0] rd_byte;
  reg rd_ok;
  integer i;
  integer k;

  assign pkg28 = (PKG_PINS == `PAMX_PKG_28);
  assign pkg20 = (PKG_PINS == `PAMX_PKG_20);

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  // Address and data are caught in either order; response after both
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_bank = aw_addr[6:5];
  assign wr_reg = aw_addr[4:2];
  // Port A has no set registers; writes to input data are answered OKAY and dropped
  assign wr_hit = ~aw_addr[7] & (wr_bank != 2'h3) &
    ((wr_reg == `PAMX_REG_OUT) | (wr_reg == `PAMX_REG_DIR) |
     (wr_reg == `PAMX_REG_ALT) | (wr_reg == `PAMX_REG_IN) |
     (((wr_reg == `PAMX_REG_SEL1) | (wr_reg == `PAMX_REG_SEL2)) &
      (wr_bank != `PAMX_BANK_A)));

  // Handshake capture and response
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PAMX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `PAMX_RESP_OKAY : `PAMX_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register store; only byte lane 0 carries data
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      // Own loop index, so the decode process keeps sole use of i
      for (k = 0; k < 3; k = k + 1) begin
        port_out[k] <= `PAMX_RST_BYTE;
        port_dir[k] <= `PAMX_RST_BYTE;
        alt_en[k] <= `PAMX_RST_BYTE;
      end
      for (k = 1; k < 3; k = k + 1) begin
        function_select_first[k] <= `PAMX_RST_BYTE;
        function_select_second[k] <= `PAMX_RST_BYTE;
      end
    end else if (wr_fire & wr_hit & w_lane0) begin
      case (wr_reg)
        `PAMX_REG_OUT: port_out[wr_bank] <= w_data;
        `PAMX_REG_DIR: port_dir[wr_bank] <= w_data;
        `PAMX_REG_ALT: alt_en[wr_bank] <= w_data;
        `PAMX_REG_SEL1: function_select_first[wr_bank] <= w_data;
        `PAMX_REG_SEL2: function_select_second[wr_bank] <= w_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_bank = s_axi_araddr[6:5];
  assign rd_reg = s_axi_araddr[4:2];
  assign rd_bank_ok = ~s_axi_araddr[7] & (rd_bank != 2'h3);

  // Port A set registers read as zero since they do not exist
  always @* begin
    rd_byte = 8'h00;
    rd_ok = rd_bank_ok;
    if (rd_bank_ok) begin
      case (rd_reg)
        `PAMX_REG_OUT: rd_byte = port_out[rd_bank];
        `PAMX_REG_DIR: rd_byte = port_dir[rd_bank];
        `PAMX_REG_ALT: rd_byte = alt_en[rd_bank];
        `PAMX_REG_SEL1: if (rd_bank != `PAMX_BANK_A)
          rd_byte = function_select_first[rd_bank];
        `PAMX_REG_SEL2: if (rd_bank != `PAMX_BANK_A)
          rd_byte = function_select_second[rd_bank];
        `PAMX_REG_IN: rd_byte = pad_in[rd_bank * 8 +: 8];
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // Answer registered on the same edge that takes the address
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PAMX_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_ok ? `PAMX_RESP_OKAY : `PAMX_RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------------
  // Only the first set register steers; the second is never read here.
  // A reserved choice leaves alt_use low so the pad stays GPIO.
  always @* begin
    alt_use = 24'h000000;
    alt_out = 24'h000000;
    alt_oe = 24'h000000;
    alt_ana = 24'h000000;
    // Port A: enable alone selects the one function
    alt_use[7:0] = alt_en[0];
    alt_out[0] = timer_zero_compl_in;
    alt_oe[0] = timer_zero_pin_drive_in;
    alt_out[1] = timer_zero_output_in;
    alt_oe[1] = 1'b1;
    alt_out[2] = uart_zero_driver_enable_in;
    alt_oe[2] = 1'b1;
    alt_out[5] = uart_zero_transmit_in;
    alt_oe[5] = 1'b1;
    alt_out[6] = timer_one_compl_in;
    alt_oe[6] = timer_one_pin_drive_in;
    alt_out[7] = timer_one_output_in;
    alt_oe[7] = 1'b1;
    // Port B: analog inputs 0-4, reference, or clock input
    for (i = 0; i < 5; i = i + 1) begin
      alt_ana[`PAMX_PB0 + i] = function_select_first[1][i];
    end
    alt_ana[`PAMX_PB5] = function_select_first[1][5] & pkg28;
    alt_use[`PAMX_PB3] = alt_en[1][3];
    for (i = 0; i < 6; i = i + 1) begin
      if (alt_ana[`PAMX_PB0 + i]) begin
        alt_use[`PAMX_PB0 + i] = alt_en[1][i];
      end
    end
    // Port C: analog/comparator, reference, comparator out or LED sink
    for (i = 0; i < 8; i = i + 1) begin
      if (function_select_first[2][i]) begin
        if (i > 2 || led_enable_in[i]) begin
          alt_use[`PAMX_PC0 + i] = alt_en[2][i];
          alt_oe[`PAMX_PC0 + i] = 1'b1;               // LED sinks low
        end else begin
          alt_use[`PAMX_PC0 + i] = alt_en[2][i];
          alt_ana[`PAMX_PC0 + i] = 1'b1;
        end
      end
    end
    if (~function_select_first[2][3]) begin
      alt_use[`PAMX_PC3] = alt_en[2][3];
      alt_out[`PAMX_PC3] = comparator_output_in;
      alt_oe[`PAMX_PC3] = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Pad stages
  // ----------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < `PAMX_PADS; p = p + 1) begin : g_pad
      pamx_pad u_pad (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .gpio_out_in(port_out[p / 8][p % 8]),
        .gpio_oe_in(port_dir[p / 8][p % 8]),
        .alt_use_in(alt_use[p]),
        .alt_out_in(alt_out[p]),
        .alt_oe_in(alt_oe[p]),
        .alt_analog_in(alt_ana[p]),
        .pad_in(pad_in[p]),
        .pad_out(pad_out[p]),
        .pad_oe_out(pad_oe_out[p]),
        .analog_out(analog_connect_out[p]),
        .alt_in_out(alt_in[p])
      );
    end
  endgenerate

  // Reference tie-in follows the pad stage timing
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      adc_ref_pad_out <= 2'h0;
    end else begin
      adc_ref_pad_out[0] <= alt_use[`PAMX_PB5] & alt_ana[`PAMX_PB5];
      adc_ref_pad_out[1] <= alt_use[`PAMX_PC2] & alt_ana[`PAMX_PC2] &
        pkg20 & adc_ref_select_in;
    end
  end

  // ----------------------------------------------------------------------
  // Peripheral inputs; each reads zero while its pad is not routed
  // ----------------------------------------------------------------------
  assign timer_zero_input_out = alt_in[0];
  assign uart_zero_clear_to_send_out = alt_in[3];
  assign uart_zero_receive_out = alt_in[4];
  assign timer_one_input_out = alt_in[6];
  assign external_clock_input_out = alt_in[`PAMX_PB3];

endmodule // pamx_port_mux

// ---- pamx_defines.vh ----
// Register map, field codes and reset values of the pin alternate-function mux
`ifndef PAMX_DEFINES_VH
`define PAMX_DEFINES_VH

// ----------------------------------------------------------------------
// Register map: one 32-byte bank per port, one word per register
// ----------------------------------------------------------------------
`define PAMX_ADDR_W 8
`define PAMX_BANK_A 2'h0
`define PAMX_BANK_B 2'h1
`define PAMX_BANK_C 2'h2
`define PAMX_REG_OUT 3'h0
`define PAMX_REG_DIR 3'h1
`define PAMX_REG_ALT 3'h2
`define PAMX_REG_SEL1 3'h3
`define PAMX_REG_SEL2 3'h4
`define PAMX_REG_IN 3'h5
`define PAMX_OFS_OUT 8'h00
`define PAMX_OFS_DIR 8'h04
`define PAMX_OFS_ALT 8'h08
`define PAMX_OFS_SEL1 8'h0C
`define PAMX_OFS_SEL2 8'h10
`define PAMX_OFS_IN 8'h14
`define PAMX_BANK_STRIDE 8'h20

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define PAMX_RST_BYTE 8'h00
`define PAMX_RESP_OKAY 2'h0
`define PAMX_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// Package variants
// ----------------------------------------------------------------------
`define PAMX_PKG_20 6'h14
`define PAMX_PKG_28 6'h1C

// ----------------------------------------------------------------------
// Pad indices (port * 8 + pin)
// ----------------------------------------------------------------------
`define PAMX_PADS 24
`define PAMX_PB0 8
`define PAMX_PB3 11
`define PAMX_PB5 13
`define PAMX_PC0 16
`define PAMX_PC2 18
`define PAMX_PC3 19

`endif

// ---- pamx_pad.v ----
// One pad's output stage: registered choice between GPIO and alternate path
`timescale 1ns/1ns
module pamx_pad (
  input wire clock_in,        // System clock
  input wire resetn_in,       // Synchronous reset, active low
  input wire gpio_out_in,     // Port output data bit
  input wire gpio_oe_in,      // Port direction bit, 1 drives
  input wire alt_use_in,      // Alternate function owns the pad
  input wire alt_out_in,      // Alternate output level
  input wire alt_oe_in,       // Alternate output enable
  input wire alt_analog_in,   // Alternate function is analog
  input wire pad_in,          // Pad level
  output reg pad_out,         // Pad output level
  output reg pad_oe_out,      // Pad output enable, 1 drives
  output reg analog_out,      // Analog switch closed
  output reg alt_in_out       // Pad level seen by the peripheral
);

  // ----------------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------------
  // One flop stage: the whole choice moves in one edge, so no mixed
  // function appears between two settings
  always @(posedge clock_in) begin
    if (!resetn_in) begin
      pad_out <= 1'b0;
      pad_oe_out <= 1'b0;
      analog_out <= 1'b0;
      alt_in_out <= 1'b0;
    end else if (alt_use_in) begin
      pad_out <= alt_out_in;
      pad_oe_out <= alt_oe_in;
      analog_out <= alt_analog_in;
      alt_in_out <= pad_in & ~alt_analog_in;
    end else begin
      pad_out <= gpio_out_in;
      pad_oe_out <= gpio_oe_in;
      analog_out <= 1'b0;
      alt_in_out <= 1'b0;
    end
  end

endmodule // pamx_pad

// ---- pamx_port_mux_monitor.sv ----
// Checker of pad routing, watching only the mux's own ports
`timescale 1ns/1ns
`include "pamx_defines.vh"
module pamx_port_mux_monitor #(
  parameter [5:0] PKG_PINS = `PAMX_PKG_28  // Package pin count
) (
  input wire clock_in,                    // System clock
  input wire resetn_in,                   // Synchronous reset, active low
  input wire [23:0] pad_in,               // Pad levels
  input wire [23:0] pad_oe_out,           // Pad output enables
  input wire [23:0] analog_connect_out,   // Pad tied to analog bus
  input wire timer_zero_input_out,        // Timer 0 input from PA0
  input wire timer_one_input_out,         // Timer 1 input from PA6
  input wire uart_zero_clear_to_send_out, // Clear to send from PA3
  input wire uart_zero_receive_out,       // Receive from PA4
  input wire external_clock_input_out,    // Clock from PB3
  input wire [1:0] adc_ref_pad_out        // Reference on PB5 / PC2
);
  // ----------------------------------------------------------------
  // Routing relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Peripheral inputs are the pad level one edge earlier, or held low; timer 1 is checked only in the cycle it rises
  property p_tmr0_in;
    timer_zero_input_out |-> $past(pad_in[0]);
  endproperty
  a_tmr0_in: assert property (p_tmr0_in)
    else $error("timer 0 input not from its pad");
  property p_tmr1_in;
    $rose(timer_one_input_out) |-> $past(pad_in[6]);
  endproperty
  a_tmr1_in: assert property (p_tmr1_in)
    else $error("timer 1 input not from its pad");
  property p_uart_rx;
    uart_zero_receive_out |-> $past(pad_in[4]);
  endproperty
  a_uart_rx: assert property (p_uart_rx)
    else $error("uart receive not from its pad");
  property p_cts;
    uart_zero_clear_to_send_out |-> $past(pad_in[3]);
  endproperty
  a_cts: assert property (p_cts)
    else $error("clear to send not from its pad");
  property p_ext_clk;
    external_clock_input_out |-> $past(pad_in[11]);
  endproperty
  a_ext_clk: assert property (p_ext_clk)
    else $error("external clock not from its pad");
  // Port A has no analog choice at all
  property p_porta_an;
    analog_connect_out[7:0] == 8'h00;
  endproperty
  a_porta_an: assert property (p_porta_an)
    else $error("port A pad on analog bus");
  // PB6/PB7 and PC3 to PC7 offer no analog function
  property p_resv_an;
    (analog_connect_out & 24'hF8C000) == 24'h000000;
  endproperty
  a_resv_an: assert property (p_resv_an)
    else $error("analog on a pad without analog function");
  // An analog pad is never driven at the same time
  property p_an_oe;
    (analog_connect_out & pad_oe_out) == 24'h000000;
  endproperty
  a_an_oe: assert property (p_an_oe)
    else $error("analog pad also driven");
  property p_ref_b;
    adc_ref_pad_out[0] |-> PKG_PINS == `PAMX_PKG_28 && analog_connect_out[13];
  endproperty
  a_ref_b: assert property (p_ref_b)
    else $error("reference on PB5 in wrong package");
  property p_ref_c;
    // Package on the left, so the check is live in the default build
    PKG_PINS != `PAMX_PKG_20 |-> !adc_ref_pad_out[1];
  endproperty
  a_ref_c: assert property (p_ref_c)
    else $error("reference on PC2 in wrong package");
endmodule // pamx_port_mux_monitor

// ---- pamx_periph_model.sv ----
// Model of the peripherals and pads around the pin mux
`timescale 1ns/1ns
module pamx_periph_model (
  input wire clock_in,            // System clock
  input wire [23:0] pad_drv_in,   // Pad levels the mux drives
  input wire [23:0] pad_oe_in,    // Pad drive enables from the mux
  input wire lvl_in,              // Level of every peripheral output
  output wire [23:0] pad_lvl_out, // Resolved pad levels
  output wire periph_out,         // Peripheral output level
  output wire pin_drive_out       // Timer mode owns its pin as output
);
  // Undriven pads flip every cycle so a stale level never passes
  reg [23:0] float_q = 24'h5A5A5A;
  always @(posedge clock_in) begin
    float_q <= ~float_q;
  end
  assign pad_lvl_out = (pad_oe_in & pad_drv_in) | (~pad_oe_in & float_q);
  // Timers, UART, comparator, LED and reference requests share one level
  assign periph_out = lvl_in;
  // Timer mode, not the port, picks input or complement output
  assign pin_drive_out = lvl_in;
endmodule // pamx_periph_model

// ---- test_pamx_port_mux.sv ----
// Self-checking bench for the pin alternate-function mux
`timescale 1ns/1ns
`include "pamx_defines.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_pamx_port_mux;
  typedef struct packed {
    logic [1:0] bank;
    logic [7:0] s1, s2, alt, dir, dout;
    logic lvl;
    logic [7:0] eoe, eout, ean;
  } pamx_row_t;
  reg clock_in = 1'b0;
  reg resetn_in = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, lvl = 1'b1;
  wire awready, wready, bvalid, arready, rvalid, periph, drive;
  wire [1:0] bresp, rresp, ref_pad;
  wire [31:0] rdata;
  wire [23:0] pad_lvl, pad_o, pad_oe, an;
  reg [1:0] resp;
  reg [31:0] rd_q;
  reg [7:0] base;
  pamx_row_t rows [9];
  pamx_row_t r;
  int i, cycles = 0, bad_count = 0, n_tests = 0;
  always #2 clock_in = ~clock_in;
  pamx_port_mux dut_u (.clock_in(clock_in), .resetn_in(resetn_in),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_lvl),
    .pad_out(pad_o), .pad_oe_out(pad_oe), .analog_connect_out(an),
    .timer_zero_output_in(periph), .timer_zero_compl_in(periph),
    .timer_zero_pin_drive_in(drive), .timer_zero_input_out(),
    .timer_one_output_in(periph), .timer_one_compl_in(periph),
    .timer_one_pin_drive_in(drive), .timer_one_input_out(),
    .uart_zero_driver_enable_in(periph), .uart_zero_clear_to_send_out(),
    .uart_zero_receive_out(), .uart_zero_transmit_in(periph),
    .external_clock_input_out(), .comparator_output_in(periph),
    .led_enable_in({8{periph}}), .adc_ref_select_in(periph),
    .adc_ref_pad_out(ref_pad));
  pamx_periph_model model_u (.clock_in(clock_in), .pad_drv_in(pad_o),
    .pad_oe_in(pad_oe), .lvl_in(lvl), .pad_lvl_out(pad_lvl),
    .periph_out(periph), .pin_drive_out(drive));
  // ----------------------------------------------------------------
  // Bus master: payload held until its own ready, answer taken at edge
  // ----------------------------------------------------------------
  task automatic wr(input [7:0] a, input [31:0] d);
    reg ta, tw, tb;
    begin
      @(posedge clock_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(negedge clock_in);
        ta = awvalid & awready;
        tw = wvalid & wready;
        tb = bvalid;
        resp = bresp;
        @(posedge clock_in);
        if (ta) awvalid <= 1'b0;
        if (tw) wvalid <= 1'b0;
      end while (!tb);
      bready <= 1'b0;
    end
  endtask
  task automatic rd(input [7:0] a);
    reg ta, tr;
    begin
      @(posedge clock_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(negedge clock_in);
        ta = arvalid & arready;
        tr = rvalid;
        rd_q = rdata;
        resp = rresp;
        @(posedge clock_in);
        if (ta) arvalid <= 1'b0;
      end while (!tr);
      rready <= 1'b0;
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    // bank s1 s2 alt dir out lvl | pad oe, pad out, analog of that port
    rows[0] = '{2'h0, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 1, 8'hE7, 8'hE7, 0};
    rows[1] = '{2'h0, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 0, 8'hA6, 8'h00, 0};
    rows[2] = '{2'h1, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 1, 8'h00, 8'h00, 0};
    rows[3] = '{2'h1, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 1, 8'h00, 8'h00,
                8'h3F};
    rows[4] = '{2'h1, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hA5, 1, 8'hF7, 8'hA5, 0};
    rows[5] = '{2'h2, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 1, 8'h08, 8'h08, 0};
    rows[6] = '{2'h2, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 0, 8'hF8, 8'h00,
                8'h07};
    rows[7] = '{2'h2, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 1, 8'hFF, 8'h00, 0};
    rows[8] = '{2'h2, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 1, 8'h00, 8'h00, 0};
    repeat (20) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd(8'h28);
    `CHK(rd_q, 32'h0)
    `CHK({pad_oe, an}, 48'h0)
    $display("reset test done");
    // Set bits are written while the enable is off, then enabled
    for (i = 0; i < 9; i++) begin
      r = rows[i];
      base = {1'b0, r.bank, 5'h00};
      @(posedge clock_in);
      lvl <= r.lvl;
      wr(base + `PAMX_OFS_ALT, 32'h0);
      wr(base + `PAMX_OFS_OUT, {24'h0, r.dout});
      wr(base + `PAMX_OFS_DIR, {24'h0, r.dir});
      if (r.bank != 2'h0) begin
        wr(base + `PAMX_OFS_SEL1, {24'h0, r.s1});
        wr(base + `PAMX_OFS_SEL2, {24'h0, r.s2});
      end
      wr(base + `PAMX_OFS_ALT, {24'h0, r.alt});
      // Pads must show the new routing one edge after the answer
      @(negedge clock_in);
      `CHK(pad_oe[r.bank*8 +: 8], r.eoe)
      `CHK(pad_o[r.bank*8 +: 8], r.eout)
      `CHK(an[r.bank*8 +: 8], r.ean)
      if (i == 3) `CHK(ref_pad, 2'h1)
      $display("row %0d done", i);
    end
    // Port A set registers do not exist; port B second set is kept
    wr(`PAMX_OFS_SEL1, 32'hFF);
    `CHK(resp, `PAMX_RESP_SLVERR)
    rd(`PAMX_OFS_SEL1);
    `CHK({resp, rd_q}, {`PAMX_RESP_OKAY, 32'h0})
    rd(8'h20 + `PAMX_OFS_SEL2);
    `CHK({resp, rd_q}, {`PAMX_RESP_OKAY, 32'hFF})
    rd(8'h80);
    `CHK(resp, `PAMX_RESP_SLVERR)
    $display("register test done");
    end_sim;
  end
endmodule // test_pamx_port_mux
bind pamx_port_mux pamx_port_mux_monitor #(.PKG_PINS(PKG_PINS)) mon_u (
  .clock_in(clock_in), .resetn_in(resetn_in), .pad_in(pad_in),
  .pad_oe_out(pad_oe_out), .analog_connect_out(analog_connect_out),
  .timer_zero_input_out(timer_zero_input_out),
  .timer_one_input_out(timer_one_input_out),
  .uart_zero_clear_to_send_out(uart_zero_clear_to_send_out),
  .uart_zero_receive_out(uart_zero_receive_out),
  .external_clock_input_out(external_clock_input_out),
  .adc_ref_pad_out(adc_ref_pad_out));
